// ===== imdr_regs.v
// mode, diagnostic and data flag registers of the inertial sensor
`default_nettype none
`include "imdr_consts.vh"

module imdr_regs #(
   parameter [15:0] PROD_WORD1 = 16'h0001, // arbitrary value
   parameter [15:0] PROD_WORD2 = 16'h0002, // arbitrary value
   parameter [15:0] PROD_WORD3 = 16'h0003, // arbitrary value
   parameter [15:0] PROD_WORD4 = 16'h0004, // arbitrary value
   parameter [15:0] FW_REV = 16'h0100, // arbitrary value
   parameter [15:0] SERIAL1 = 16'h0A01, // arbitrary value
   parameter [15:0] SERIAL2 = 16'h0A02, // arbitrary value
   parameter [15:0] SERIAL3 = 16'h0A03, // arbitrary value
   parameter [15:0] SERIAL4 = 16'h0A04 // arbitrary value
) (
   input wire clk, // system clock
   input wire rst, // synchronous reset, active high
   input wire reg_wr, // register write strobe
   input wire reg_rd, // register read strobe
   input wire [6:0] reg_addr, // byte address, even
   input wire [15:0] reg_wdata, // write data
   output reg [15:0] reg_rdata, // read data, one cycle after strobe
   output reg rdata_valid, // read data valid pulse
   output reg burst_start, // burst read start pulse
   output reg sampling_mode, // 1 while in sampling mode
   output reg mode_busy, // mode transition in progress
   input wire [3:0] selftest_fail_bits, // xgyro,ygyro,zgyro,accel
   input wire delta_out_en, // delta outputs enabled
   input wire cfg_combo_bad, // rate/filter combo not allowed
   input wire angle_accum_overflow, // delta angle overflow
   input wire velocity_accum_overflow, // delta velocity overflow
   input wire [1:0] startup_hw_fault, // startup check code
   input wire serial_cmd_overrun, // commands too close
   input wire async_tx_overrun, // tx demand above baud
   input wire flash_test_fail, // memory read test failed
   input wire nvm_backup_fail, // general backup failed
   input wire rot_backup_fail, // rotation backup failed
   input wire rot_backup_done, // rotation backup finished
   input wire [12:0] new_data_set, // temp..zaccl, xdlta..zdltv
   input wire [5:0] range_over_set, // xgyro..zaccl over range
   output reg rotation_save_trigger, // rotation save request pulse
   output reg [15:0] rot_coeff_r3c2, // rotation coefficient r3c2
   output reg [15:0] rot_coeff_r3c3, // rotation coefficient r3c3
   output reg register_window_select // current window
);

   // mode sequencer states
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_SWITCH = 2'b10;

   // transition length, rounded up to whole cycles
   localparam integer MODE_SW_CYC_I =
      (`IMDR_MODE_SW_NS + `IMDR_CLK_NS - 1) / `IMDR_CLK_NS;
   localparam [7:0] MODE_SW_CYC = MODE_SW_CYC_I[7:0];

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] sw_cnt_ff;
   reg [7:0] nxt_sw_cnt;
   reg [1:0] mode_cmd_ff;
   reg [1:0] nxt_mode_cmd;
   reg sampling_ff;
   reg nxt_sampling;
   reg rot_busy_ff;
   reg [15:0] nxt_rdata;

   wire win0;
   wire win1;
   wire wr0;
   wire wr1;
   wire rd0;
   wire [15:0] diag_q;
   wire [12:0] fresh_q;
   wire [5:0] range_q;
   wire [15:0] diag_set;
   wire diag_rd;
   wire range_rd;
   wire [12:0] fresh_rd;
   wire [15:0] diag_word;
   wire [15:0] flag_word;
   wire [15:0] range_word;
   wire [15:0] mode_word;
   wire [15:0] syscmd2_word;
   wire [1:0] wr_cmd;

   // window decode
   assign win1 = register_window_select;
   assign win0 = ~register_window_select;
   assign wr0 = reg_wr & win0;
   assign wr1 = reg_wr & win1;
   assign rd0 = reg_rd & win0;

   // diagnostic event sources
   assign diag_set[15] = 1'b0;
   assign diag_set[14:11] = selftest_fail_bits;
   assign diag_set[10] = ~delta_out_en & cfg_combo_bad;
   assign diag_set[9] = angle_accum_overflow;
   assign diag_set[8] = velocity_accum_overflow;
   assign diag_set[7] = 1'b0;
   assign diag_set[6:5] = startup_hw_fault;
   assign diag_set[4] = serial_cmd_overrun;
   assign diag_set[3] = async_tx_overrun;
   assign diag_set[2] = flash_test_fail;
   assign diag_set[1] = 1'b0;
   assign diag_set[0] = nvm_backup_fail | rot_backup_fail;

   // read-clear strobes
   assign diag_rd = rd0 & (reg_addr == `IMDR_ADDR_DIAG);
   assign range_rd = rd0 & (reg_addr == `IMDR_ADDR_RANGE);
   assign fresh_rd[12] = rd0 & (reg_addr == `IMDR_ADDR_TEMP_HI);
   assign fresh_rd[11] = rd0 & (reg_addr == `IMDR_ADDR_XGYRO_HI);
   assign fresh_rd[10] = rd0 & (reg_addr == `IMDR_ADDR_YGYRO_HI);
   assign fresh_rd[9] = rd0 & (reg_addr == `IMDR_ADDR_ZGYRO_HI);
   assign fresh_rd[8] = rd0 & (reg_addr == `IMDR_ADDR_XACCL_HI);
   assign fresh_rd[7] = rd0 & (reg_addr == `IMDR_ADDR_YACCL_HI);
   assign fresh_rd[6] = rd0 & (reg_addr == `IMDR_ADDR_ZACCL_HI);
   assign fresh_rd[5] = rd0 & (reg_addr == `IMDR_ADDR_XDLTA_HI);
   assign fresh_rd[4] = rd0 & (reg_addr == `IMDR_ADDR_YDLTA_HI);
   assign fresh_rd[3] = rd0 & (reg_addr == `IMDR_ADDR_ZDLTA_HI);
   assign fresh_rd[2] = rd0 & (reg_addr == `IMDR_ADDR_XDLTV_HI);
   assign fresh_rd[1] = rd0 & (reg_addr == `IMDR_ADDR_YDLTV_HI);
   assign fresh_rd[0] = rd0 & (reg_addr == `IMDR_ADDR_ZDLTV_HI);

   // diagnostic results, cleared by a diag read
   imdr_sticky #(
      .W(16)
   ) u_diag (
      .clk(clk),
      .rst(rst),
      .set(diag_set),
      .clr(diag_rd),
      .q(diag_q)
   );

   // axis over-range flags, cleared by a range read
   imdr_sticky #(
      .W(6)
   ) u_range (
      .clk(clk),
      .rst(rst),
      .set(range_over_set),
      .clr(range_rd),
      .q(range_q)
   );

   // one new-data flag per channel
   genvar gi;
   generate
      for (gi = 0; gi < 13; gi = gi + 1)
      begin : g_fresh
         imdr_sticky #(
            .W(1)
         ) u_fresh (
            .clk(clk),
            .rst(rst),
            .set(new_data_set[gi]),
            .clr(fresh_rd[gi]),
            .q(fresh_q[gi])
         );
      end
   endgenerate

   // assembled status words
   assign diag_word = {diag_q[15:2],
                       |diag_q[14:11],
                       diag_q[0]};
   assign flag_word = {fresh_q[12:6],
                       |range_q,
                       fresh_q[5:0],
                       1'b0,
                       |diag_word};
   assign range_word = {2'h0, range_q, 8'h00};
   assign mode_word = {5'h00, ~sampling_ff, mode_cmd_ff, 8'h00};
   assign syscmd2_word = {7'h00, rot_busy_ff, 8'h00};

   // write command extraction
   assign wr_cmd = reg_wdata[`IMDR_MODE_CMD_HI:`IMDR_MODE_CMD_LO];

   // mode sequencer next state
   always @*
   begin
      nxt_state = state_ff;
      nxt_sw_cnt = sw_cnt_ff;
      nxt_mode_cmd = mode_cmd_ff;
      nxt_sampling = sampling_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (wr0 && (reg_addr == `IMDR_ADDR_MODE) &&
                ((wr_cmd == `IMDR_CMD_SAMPLE) ||
                 (wr_cmd == `IMDR_CMD_CONFIG)))
            begin
               nxt_mode_cmd = wr_cmd;
               nxt_sw_cnt = MODE_SW_CYC;
               nxt_state = ST_SWITCH;
            end
         end
         ST_SWITCH:
         begin
            if (sw_cnt_ff == 8'h01)
            begin
               nxt_sampling = (mode_cmd_ff == `IMDR_CMD_SAMPLE);
               nxt_mode_cmd = `IMDR_CMD_NONE;
               nxt_sw_cnt = 8'h00;
               nxt_state = ST_IDLE;
            end
            else
               nxt_sw_cnt = sw_cnt_ff - 8'h01;
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_mode_cmd = `IMDR_CMD_NONE;
            nxt_sw_cnt = 8'h00;
         end
      endcase
   end

   // mode sequencer registers
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= ST_IDLE;
         sw_cnt_ff <= 8'h00;
         mode_cmd_ff <= `IMDR_CMD_NONE;
         sampling_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         sw_cnt_ff <= nxt_sw_cnt;
         mode_cmd_ff <= nxt_mode_cmd;
         sampling_ff <= nxt_sampling;
      end
   end

   // mode outputs from flops
   always @(posedge clk)
   begin
      if (rst)
      begin
         sampling_mode <= 1'b0;
         mode_busy <= 1'b0;
      end
      else
      begin
         sampling_mode <= nxt_sampling;
         mode_busy <= (nxt_state == ST_SWITCH);
      end
   end

   // burst start pulse
   always @(posedge clk)
   begin
      if (rst)
         burst_start <= 1'b0;
      else
         burst_start <= wr0 && (reg_addr == `IMDR_ADDR_BURST) &&
                        (reg_wdata[7:0] == `IMDR_BURST_GO);
   end

   // window select, writable from either window
   always @(posedge clk)
   begin
      if (rst)
         register_window_select <= `IMDR_RST_WINSEL;
      else if (reg_wr && (reg_addr == `IMDR_ADDR_WINSEL))
         register_window_select <= reg_wdata[0];
   end

   // rotation coefficients
   always @(posedge clk)
   begin
      if (rst)
      begin
         rot_coeff_r3c2 <= `IMDR_RST_ROT_R3C2;
         rot_coeff_r3c3 <= `IMDR_RST_ROT_R3C3;
      end
      else
      begin
         if (wr1 && (reg_addr == `IMDR_ADDR_ROT_R3C2))
            rot_coeff_r3c2 <= reg_wdata;
         if (wr1 && (reg_addr == `IMDR_ADDR_ROT_R3C3))
            rot_coeff_r3c3 <= reg_wdata;
      end
   end

   // rotation save request and busy bit
   always @(posedge clk)
   begin
      if (rst)
      begin
         rotation_save_trigger <= 1'b0;
         rot_busy_ff <= 1'b0;
      end
      else
      begin
         rotation_save_trigger <= 1'b0;
         if (wr1 && (reg_addr == `IMDR_ADDR_SYSCMD2) &&
             reg_wdata[`IMDR_ROT_SAVE_BIT] && !rot_busy_ff)
         begin
            rotation_save_trigger <= 1'b1;
            rot_busy_ff <= 1'b1;
         end
         else if (rot_backup_done)
            rot_busy_ff <= 1'b0;
      end
   end

   // read data selection
   always @*
   begin
      nxt_rdata = 16'h0000;
      if (reg_addr == `IMDR_ADDR_WINSEL)
         nxt_rdata = {15'h0000, register_window_select};
      else if (win0)
      begin
         case (reg_addr)
            `IMDR_ADDR_MODE: nxt_rdata = mode_word;
            `IMDR_ADDR_DIAG: nxt_rdata = diag_word;
            `IMDR_ADDR_FLAGS: nxt_rdata = flag_word;
            `IMDR_ADDR_RANGE: nxt_rdata = range_word;
            default: nxt_rdata = 16'h0000;
         endcase
      end
      else
      begin
         case (reg_addr)
            `IMDR_ADDR_SYSCMD2: nxt_rdata = syscmd2_word;
            `IMDR_ADDR_ROT_R3C2: nxt_rdata = rot_coeff_r3c2;
            `IMDR_ADDR_ROT_R3C3: nxt_rdata = rot_coeff_r3c3;
            `IMDR_ADDR_PROD1: nxt_rdata = PROD_WORD1;
            `IMDR_ADDR_PROD2: nxt_rdata = PROD_WORD2;
            `IMDR_ADDR_PROD3: nxt_rdata = PROD_WORD3;
            `IMDR_ADDR_PROD4: nxt_rdata = PROD_WORD4;
            `IMDR_ADDR_FWREV: nxt_rdata = FW_REV;
            `IMDR_ADDR_SER1: nxt_rdata = SERIAL1;
            `IMDR_ADDR_SER2: nxt_rdata = SERIAL2;
            `IMDR_ADDR_SER3: nxt_rdata = SERIAL3;
            `IMDR_ADDR_SER4: nxt_rdata = SERIAL4;
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   // read data register, value before any read-clear
   always @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 16'h0000;
         rdata_valid <= 1'b0;
      end
      else
      begin
         rdata_valid <= reg_rd;
         if (reg_rd)
            reg_rdata <= nxt_rdata;
      end
   end

endmodule // imdr_regs

`default_nettype wire

// ===== imdr_consts.vh
// register offsets, field positions, reset values and timing for imdr
`ifndef IMDR_CONSTS_VH
`define IMDR_CONSTS_VH

// window 0 byte offsets
`define IMDR_ADDR_BURST 7'h00
`define IMDR_ADDR_MODE 7'h02
`define IMDR_ADDR_DIAG 7'h04
`define IMDR_ADDR_FLAGS 7'h06
`define IMDR_ADDR_RANGE 7'h0C
`define IMDR_ADDR_TEMP_HI 7'h0E
`define IMDR_ADDR_XGYRO_HI 7'h12
`define IMDR_ADDR_YGYRO_HI 7'h16
`define IMDR_ADDR_ZGYRO_HI 7'h1A
`define IMDR_ADDR_XACCL_HI 7'h1E
`define IMDR_ADDR_YACCL_HI 7'h22
`define IMDR_ADDR_ZACCL_HI 7'h26
`define IMDR_ADDR_XDLTA_HI 7'h64
`define IMDR_ADDR_YDLTA_HI 7'h68
`define IMDR_ADDR_ZDLTA_HI 7'h6C
`define IMDR_ADDR_XDLTV_HI 7'h70
`define IMDR_ADDR_YDLTV_HI 7'h74
`define IMDR_ADDR_ZDLTV_HI 7'h78

// window 1 byte offsets
`define IMDR_ADDR_SYSCMD2 7'h16
`define IMDR_ADDR_ROT_R3C2 7'h46
`define IMDR_ADDR_ROT_R3C3 7'h48
`define IMDR_ADDR_PROD1 7'h6A
`define IMDR_ADDR_PROD2 7'h6C
`define IMDR_ADDR_PROD3 7'h6E
`define IMDR_ADDR_PROD4 7'h70
`define IMDR_ADDR_FWREV 7'h72
`define IMDR_ADDR_SER1 7'h74
`define IMDR_ADDR_SER2 7'h76
`define IMDR_ADDR_SER3 7'h78
`define IMDR_ADDR_SER4 7'h7A

// both windows
`define IMDR_ADDR_WINSEL 7'h7E

// field positions
`define IMDR_BURST_GO 8'h00
`define IMDR_MODE_STAT_BIT 10
`define IMDR_MODE_CMD_HI 9
`define IMDR_MODE_CMD_LO 8
`define IMDR_CMD_SAMPLE 2'h1
`define IMDR_CMD_CONFIG 2'h2
`define IMDR_CMD_NONE 2'h0
`define IMDR_ROT_SAVE_BIT 8
`define IMDR_FLAG_RANGE_BIT 8
`define IMDR_FLAG_FAULT_BIT 0
`define IMDR_DIAG_SUMMARY_BIT 1

// reset values
`define IMDR_RST_ROT_R3C2 16'h0000
`define IMDR_RST_ROT_R3C3 16'h4000
`define IMDR_RST_WINSEL 1'h0

// timing
`define IMDR_CLK_NS 10
`define IMDR_MODE_SW_NS 1000

`endif

// ===== imdr_sticky.v
// sticky flag bank: set wins over clear
`default_nettype none

module imdr_sticky #(
   parameter W = 1
) (
   input wire clk, // system clock
   input wire rst, // synchronous reset, active high
   input wire [W-1:0] set, // per-bit set pulses
   input wire clr, // clear all bits
   output wire [W-1:0] q // flag state
);

   reg [W-1:0] flag_ff;
   wire [W-1:0] nxt_flag;

   // a set arriving with the clear survives
   assign nxt_flag = (flag_ff & ~{W{clr}}) | set;

   // flag storage
   always @(posedge clk)
   begin
      if (rst)
         flag_ff <= {W{1'b0}};
      else
         flag_ff <= nxt_flag;
   end

   assign q = flag_ff;

endmodule // imdr_sticky

`default_nettype wire

// ===== imdr_chk.sv
// assertion checker for the imdr register block
`default_nettype none
module imdr_chk (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [6:0] reg_addr, // address
   input wire logic [15:0] reg_wdata, // write data
   input wire logic [15:0] reg_rdata, // read data
   input wire logic rdata_valid, // read valid
   input wire logic burst_start, // burst pulse
   input wire logic sampling_mode, // mode
   input wire logic mode_busy, // transition
   input wire logic rotation_save_trigger, // save pulse
   input wire logic rot_backup_done, // save finished
   input wire logic register_window_select // window
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic save_busy;
   // save in progress: further save requests are ignored meanwhile
   always @(posedge clk)
   begin
      if (rst)
         save_busy <= 1'b0;
      else if (rotation_save_trigger)
         save_busy <= 1'b1;
      else if (rot_backup_done)
         save_busy <= 1'b0;
   end
   // every read strobe gives a valid pulse next cycle
   a_rdata_valid_pulse: assert property (reg_rd |=> rdata_valid)
      else $error("read valid pulse missing");
   // burst pulse only for a zero low byte
   a_burst_zero_go: assert property (reg_wr && reg_addr == 7'h00 &&
      !register_window_select |=> burst_start ==
      ($past(reg_wdata[7:0]) == 8'h00)) else $error("burst pulse wrong");
   // status bit mirrors the mode
   a_mode_stat_read: assert property (rdata_valid &&
      $past(reg_addr) == 7'h02 && !$past(register_window_select)
      |-> reg_rdata[10] == !$past(sampling_mode))
      else $error("mode status bit wrong");
   // transition lasts exactly 100 cycles
   a_mode_sw_time: assert property ($rose(mode_busy) |->
      ##99 mode_busy ##1 !mode_busy) else $error("switch time wrong");
   // sampling command ends in sampling mode
   a_cmd_to_sample: assert property (reg_wr && reg_addr == 7'h02 &&
      !register_window_select && !mode_busy && reg_wdata[9:8] == 2'h1
      |=> ##101 sampling_mode) else $error("no sampling mode");
   // configuration command ends in configuration mode
   a_cmd_to_config: assert property (reg_wr && reg_addr == 7'h02 &&
      !register_window_select && !mode_busy && reg_wdata[9:8] == 2'h2
      |=> ##101 !sampling_mode) else $error("no config mode");
   // mode changes only at the end of a transition
   a_mode_hold: assert property ($changed(sampling_mode) |->
      $past(mode_busy)) else $error("mode changed without command");
   // self-test summary follows its four bits
   a_st_summary: assert property (rdata_valid &&
      $past(reg_addr) == 7'h04 && !$past(register_window_select)
      |-> reg_rdata[1] == |reg_rdata[14:11]) else $error("summary wrong");
   // rotation save bit gives a trigger pulse
   a_rot_save_go: assert property (reg_wr && reg_addr == 7'h16 &&
      register_window_select && reg_wdata[8] && !save_busy &&
      !rotation_save_trigger |=> rotation_save_trigger)
      else $error("no rotation save pulse");
   // window select takes bit 0 of the write
   a_win_update: assert property (reg_wr && reg_addr == 7'h7E |=>
      register_window_select == $past(reg_wdata[0]))
      else $error("window select wrong");
   cover property (burst_start);
   cover property ($fell(mode_busy));
   cover property (rotation_save_trigger);
endmodule // imdr_chk

bind imdr_regs imdr_chk i_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .rdata_valid(rdata_valid),
   .burst_start(burst_start), .sampling_mode(sampling_mode),
   .mode_busy(mode_busy), .rotation_save_trigger(rotation_save_trigger),
   .rot_backup_done(rot_backup_done),
   .register_window_select(register_window_select));
`default_nettype wire

// ===== imdr_host.sv
// host model issuing register reads and writes
`default_nettype none
module imdr_host (
   input wire logic clk, // system clock
   input wire logic [15:0] rdata, // read data
   output logic wr, // write strobe
   output logic rd, // read strobe
   output logic [6:0] addr, // byte address
   output logic [15:0] wdata // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      wr = 1'h0;
      rd = 1'h0;
      addr = 7'h00;
      wdata = 16'h0000;
   end
   // one-cycle write strobe, never back to back
   task automatic wr16(input logic [6:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   // one-cycle read strobe, data taken a cycle later
   task automatic rd16(input logic [6:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      @(posedge clk);
      #1;
      v = rdata;
   endtask
endmodule // imdr_host
`default_nettype wire

// ===== imdr_regs_tb.sv
// self-checking bench for the imdr register block
`default_nettype none
module imdr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic w; logic [6:0] a; logic [15:0] e;} imdr_row_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [34:0] ev = 35'h0;
   wire logic wr, rd, valid, burst, smode, busy, trig, win;
   wire logic [6:0] addr;
   wire logic [15:0] wdata, rdata, c32, c33;
   int n_errors = 0;
   int n_tests = 0;
   int k;
   logic [6:0] fresh_addr[13] = '{7'h0E, 7'h12, 7'h16, 7'h1A, 7'h1E,
      7'h22, 7'h26, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74, 7'h78};
   imdr_row_t rows[18] = '{'{1'h0, 7'h02, 16'h0400},
      '{1'h0, 7'h04, 16'h0}, '{1'h0, 7'h06, 16'h0}, '{1'h0, 7'h7E, 16'h0},
      '{1'h0, 7'h05, 16'h0}, '{1'h1, 7'h04, 16'h0}, '{1'h1, 7'h46, 16'h0},
      '{1'h1, 7'h48, 16'h4000}, '{1'h1, 7'h6A, 16'h0001},
      '{1'h1, 7'h6C, 16'h0002}, '{1'h1, 7'h6E, 16'h0003},
      '{1'h1, 7'h70, 16'h0004}, '{1'h1, 7'h72, 16'h0100},
      '{1'h1, 7'h74, 16'h0A01}, '{1'h1, 7'h76, 16'h0A02},
      '{1'h1, 7'h78, 16'h0A03}, '{1'h1, 7'h7A, 16'h0A04},
      '{1'h1, 7'h7E, 16'h0001}};
   // free-running clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   imdr_host i_host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd),
      .addr(addr), .wdata(wdata));
   imdr_regs i_dut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .rdata_valid(valid), .burst_start(burst), .sampling_mode(smode),
      .mode_busy(busy), .selftest_fail_bits(ev[3:0]),
      .delta_out_en(ev[4]), .cfg_combo_bad(ev[5]),
      .angle_accum_overflow(ev[6]), .velocity_accum_overflow(ev[7]),
      .startup_hw_fault(ev[9:8]), .serial_cmd_overrun(ev[10]),
      .async_tx_overrun(ev[11]), .flash_test_fail(ev[12]),
      .nvm_backup_fail(ev[13]), .rot_backup_fail(ev[14]),
      .rot_backup_done(ev[15]), .new_data_set(ev[28:16]),
      .range_over_set(ev[34:29]), .rotation_save_trigger(trig),
      .rot_coeff_r3c2(c32), .rot_coeff_r3c3(c33),
      .register_window_select(win));
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // read a word and compare it
   task automatic rdc(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] d;
      i_host.rd16(a, d);
      chk(d, e);
   endtask
   // one-cycle pulse on the event inputs
   task automatic pulse(input logic [34:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 35'h0;
   endtask
   // mode command then bounded wait for the end
   task automatic mode_cmd(input logic [15:0] v);
      i_host.wr16(7'h02, v);
      // sampling command issued from config, config command from sampling
      rdc(7'h02, {5'h0, v[8], v[9:8], 8'h0});
      k = 0;
      while (busy !== 1'h0 && k < 300)
      begin
         @(posedge clk);
         k++;
      end
      chk(busy, 1'h0);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      #200us;
      n_errors++;
      final_report;
   end
   // main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      foreach (rows[i])
      begin
         i_host.wr16(7'h7E, {15'h0, rows[i].w});
         rdc(rows[i].a, rows[i].e);
      end
      chk(c33, 16'h4000);
      i_host.wr16(7'h7E, 16'h0);
      $display("reset values done");
      i_host.wr16(7'h00, 16'hFF00);
      #1 chk(burst, 1'h1);
      i_host.wr16(7'h00, 16'h0001);
      #1 chk(burst, 1'h0);
      $display("burst done");
      mode_cmd(16'h0100);
      chk(smode, 1'h1);
      rdc(7'h02, 16'h0000);
      i_host.wr16(7'h02, 16'h0300);
      #1 chk(busy, 1'h0);
      i_host.wr16(7'h02, 16'h0000);
      rdc(7'h02, 16'h0000);
      mode_cmd(16'h0200);
      chk(smode, 1'h0);
      rdc(7'h02, 16'h0400);
      $display("mode done");
      pulse(35'h3EEA);
      rdc(7'h06, 16'h0001);
      rdc(7'h04, 16'h575F);
      rdc(7'h04, 16'h0000);
      rdc(7'h06, 16'h0000);
      pulse(35'h4030);
      rdc(7'h04, 16'h0001);
      $display("diagnostics done");
      pulse(35'h43FFF0000);
      rdc(7'h06, 16'hFFFC);
      rdc(7'h0C, 16'h2100);
      rdc(7'h06, 16'hFEFC);
      foreach (fresh_addr[i])
         rdc(fresh_addr[i], 16'h0000);
      rdc(7'h06, 16'h0000);
      $display("data flags done");
      i_host.wr16(7'h7E, 16'h0001);
      i_host.wr16(7'h16, 16'h0100);
      #1 chk(trig, 1'h1);
      rdc(7'h16, 16'h0100);
      pulse(35'h8000);
      rdc(7'h16, 16'h0000);
      i_host.wr16(7'h46, 16'h1234);
      rdc(7'h46, 16'h1234);
      chk(c32, 16'h1234);
      i_host.wr16(7'h6A, 16'hFFFF);
      rdc(7'h6A, 16'h0001);
      @(posedge clk);
      rst <= 1'h1;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      rdc(7'h7E, 16'h0000);
      rdc(7'h02, 16'h0400);
      $display("rotation and reset done");
      final_report;
   end
endmodule // imdr_regs_tb
`default_nettype wire
